//--- shared/prot_irq_pkg.sv
// Package: register map, field positions and reset values for protocol interrupt gating
package prot_irq_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] FLAGS_0_OFS  = 8'h0c;
    localparam logic [7:0] FLAGS_1_OFS  = 8'h0e;
    localparam logic [7:0] ENABLE_0_OFS = 8'h10;
    localparam logic [7:0] ENABLE_1_OFS = 8'h12;
    localparam logic [7:0] PENDING_OFS  = 8'h14;

    // Reset values
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] FLAGS_RST  = 16'h0000;

    // Implemented bits; bits 7:6 and 3:0 of the second group are reserved
    localparam logic [15:0] GROUP_0_MASK = 16'hffff;
    localparam logic [15:0] GROUP_1_MASK = 16'hff30;

    // First group field positions
    localparam int unsigned FATAL_ERROR_BIT     = 15;
    localparam int unsigned INTERNAL_ERROR_BIT  = 14;
    localparam int unsigned ILLEGAL_CONFIG_BIT  = 13;
    localparam int unsigned COLDSTART_ABORT_BIT = 12;
    localparam int unsigned MISSING_RATE_BIT    = 11;
    localparam int unsigned MISSING_OFFSET_BIT  = 10;
    localparam int unsigned CORR_LIMIT_BIT      = 9;
    localparam int unsigned MAX_SYNC_BIT        = 8;
    localparam int unsigned TEST_SYMBOL_BIT     = 7;
    localparam int unsigned LATEST_TX_B_BIT     = 6;
    localparam int unsigned LATEST_TX_A_BIT     = 5;
    localparam int unsigned BOUNDARY_B_BIT      = 4;
    localparam int unsigned BOUNDARY_A_BIT      = 3;
    localparam int unsigned TIMER_TWO_BIT       = 2;
    localparam int unsigned TIMER_ONE_BIT       = 1;
    localparam int unsigned CYCLE_START_BIT     = 0;

    // Second group field positions
    localparam int unsigned ERROR_MODE_BIT      = 15;
    localparam int unsigned ILLEGAL_CMD_BIT     = 14;
    localparam int unsigned ENGINE_FAIL_BIT     = 13;
    localparam int unsigned STATE_CHANGE_BIT    = 12;
    localparam int unsigned SLOT_COUNTER_LSB    = 8;
    localparam int unsigned SLOT_COUNTER_MSB    = 11;
    localparam int unsigned EVEN_TABLE_BIT      = 5;
    localparam int unsigned ODD_TABLE_BIT       = 4;

endpackage

//--- verilog/flag_group.sv
// Sticky flag group with write-one-to-clear and enable gating
`timescale 1ns/10ps
module flag_group
    import prot_irq_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter logic [15:0] MASK  = 16'hffff
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] set_evt,
    input  wire logic             clr_we,
    input  wire logic [WIDTH-1:0] clr_data,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] flags,
    output logic                  pending
);

    // Masks and reset values are 16 bits wide, so other widths cannot be served
    if (WIDTH != 16) begin : g_width_check
        $error("flag_group supports only 16-bit groups");
    end

    logic [WIDTH-1:0] flags_nxt;

    // Set wins over a simultaneous clear; a 0 written leaves a flag alone
    always_comb begin
        flags_nxt = flags;
        if (clr_we) begin
            flags_nxt = flags_nxt & ~clr_data;
        end
        flags_nxt = (flags_nxt | set_evt) & MASK;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= FLAGS_RST;
        end else begin
            flags <= flags_nxt;
        end
    end

    // Flags set even when gated off; only the request is blocked
    assign pending = |(flags & enable & MASK);

endmodule

//--- verilog/protocol_irq_gate.sv
// Protocol interrupt enable gating: enable registers, flag groups, request output
// What this block does
// - First enable register gates first flag group
// - Bit 15 gates fatal protocol error
// - Bit 14 gates internal protocol error
// - Bit 13 gates illegal configuration
// - Bit 12 gates cold start abort
// - Bits 11,10 gate missing rate/offset correction
// - Bit 9 gates correction limit reached
// - Bit 8 gates max sync frames
// - Bit 7 gates test symbol received
// - Bits 6,5 gate latest transmit B/A
// - Bits 4,3 gate boundary violation B/A
// - Bit 1 gates timer one expired
// - Bit 2 gates timer two expired
// - Bit 0 gates cycle start
// - Second enable register gates second flag group
// - Bit 15 gates error mode changed
// - Bit 14 gates illegal control command
// - Bit 13 gates engine communication failure
// - Bit 12 gates protocol state changed
// - Bits 11-8 gate four slot counters
// - Bits 5,4 gate even/odd table written
// - Writing one clears flag, zero keeps
// - Simultaneous set and clear keeps set
`timescale 1ns/10ps
module protocol_irq_gate
    import prot_irq_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              fatal_error_set,
    input  wire logic              internal_error_set,
    input  wire logic              illegal_config_set,
    input  wire logic              coldstart_abort_set,
    input  wire logic              missing_rate_corr_set,
    input  wire logic              missing_offset_corr_set,
    input  wire logic              corr_limit_set,
    input  wire logic              max_sync_set,
    input  wire logic              test_symbol_set,
    input  wire logic              latest_tx_b_set,
    input  wire logic              latest_tx_a_set,
    input  wire logic              boundary_viol_b_set,
    input  wire logic              boundary_viol_a_set,
    input  wire logic              timer_two_set,
    input  wire logic              timer_one_set,
    input  wire logic              cycle_start_set,
    input  wire logic              error_mode_change_set,
    input  wire logic              illegal_command_set,
    input  wire logic              engine_comm_fail_set,
    input  wire logic              state_change_set,
    input  wire logic [3:0]        slot_counter_set,
    input  wire logic              even_table_set,
    input  wire logic              odd_table_set,
    output logic                   protocol_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [15:0] protocol_irq_enable_0_r;
    logic [15:0] protocol_irq_enable_1_r;
    logic [15:0] protocol_flags_0;
    logic [15:0] protocol_flags_1;
    logic [15:0] set_0;
    logic [15:0] set_1;
    logic        pending_0;
    logic        pending_1;
    logic        wr_en_0;
    logic        wr_en_1;
    logic        wr_fl_0;
    logic        wr_fl_1;
    logic [15:0] rdata_nxt;

    // Address decode shared by every write path
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_en_0 = wr_stb && hit(addr, ENABLE_0_OFS);
    assign wr_en_1 = wr_stb && hit(addr, ENABLE_1_OFS);
    assign wr_fl_0 = wr_stb && hit(addr, FLAGS_0_OFS);
    assign wr_fl_1 = wr_stb && hit(addr, FLAGS_1_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Enable registers, writable any time

    // First group enables; each bit is a plain gate per flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            protocol_irq_enable_0_r <= ENABLE_RST;
        end else if (wr_en_0) begin
            protocol_irq_enable_0_r <= wdata & GROUP_0_MASK;
        end
    end

    // Second group enables; reserved bits stay zero so they read back zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            protocol_irq_enable_1_r <= ENABLE_RST;
        end else if (wr_en_1) begin
            protocol_irq_enable_1_r <= wdata & GROUP_1_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event mapping onto flag positions

    // First group: bit positions match the enable bits that gate them
    always_comb begin
        set_0                      = 16'h0000;
        set_0[FATAL_ERROR_BIT]     = fatal_error_set;
        set_0[INTERNAL_ERROR_BIT]  = internal_error_set;
        set_0[ILLEGAL_CONFIG_BIT]  = illegal_config_set;
        set_0[COLDSTART_ABORT_BIT] = coldstart_abort_set;
        set_0[MISSING_RATE_BIT]    = missing_rate_corr_set;
        set_0[MISSING_OFFSET_BIT]  = missing_offset_corr_set;
        set_0[CORR_LIMIT_BIT]      = corr_limit_set;
        set_0[MAX_SYNC_BIT]        = max_sync_set;
        set_0[TEST_SYMBOL_BIT]     = test_symbol_set;
        set_0[LATEST_TX_B_BIT]     = latest_tx_b_set;
        set_0[LATEST_TX_A_BIT]     = latest_tx_a_set;
        set_0[BOUNDARY_B_BIT]      = boundary_viol_b_set;
        set_0[BOUNDARY_A_BIT]      = boundary_viol_a_set;
        set_0[TIMER_TWO_BIT]       = timer_two_set;
        set_0[TIMER_ONE_BIT]       = timer_one_set;
        set_0[CYCLE_START_BIT]     = cycle_start_set;
    end

    // Second group: reserved positions never set
    always_comb begin
        set_1                   = 16'h0000;
        set_1[ERROR_MODE_BIT]   = error_mode_change_set;
        set_1[ILLEGAL_CMD_BIT]  = illegal_command_set;
        set_1[ENGINE_FAIL_BIT]  = engine_comm_fail_set;
        set_1[STATE_CHANGE_BIT] = state_change_set;
        set_1[SLOT_COUNTER_MSB:SLOT_COUNTER_LSB] = slot_counter_set;
        set_1[EVEN_TABLE_BIT]   = even_table_set;
        set_1[ODD_TABLE_BIT]    = odd_table_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag groups

    flag_group #(
        .WIDTH (16),
        .MASK  (GROUP_0_MASK)
    ) u_group_0 (
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (set_0),
        .clr_we   (wr_fl_0),
        .clr_data (wdata),
        .enable   (protocol_irq_enable_0_r),
        .flags    (protocol_flags_0),
        .pending  (pending_0)
    );

    flag_group #(
        .WIDTH (16),
        .MASK  (GROUP_1_MASK)
    ) u_group_1 (
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (set_1),
        .clr_we   (wr_fl_1),
        .clr_data (wdata),
        .enable   (protocol_irq_enable_1_r),
        .flags    (protocol_flags_1),
        .pending  (pending_1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request output, registered so it leaves straight from a flip-flop

    // One cycle behind the flags; keeps the pin glitch free
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            protocol_irq <= 1'b0;
        end else begin
            protocol_irq <= pending_0 | pending_1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: data valid in the cycle after the read strobe only

    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_stb) begin
            unique case (addr)
                FLAGS_0_OFS:  rdata_nxt = protocol_flags_0;
                FLAGS_1_OFS:  rdata_nxt = protocol_flags_1;
                ENABLE_0_OFS: rdata_nxt = protocol_irq_enable_0_r;
                ENABLE_1_OFS: rdata_nxt = protocol_irq_enable_1_r;
                PENDING_OFS:  rdata_nxt = {14'h0000, pending_1, pending_0};
                default:      rdata_nxt = 16'h0000; // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_fatal_enabled;
        protocol_irq_enable_0_r[FATAL_ERROR_BIT] && fatal_error_set && !wr_en_0;
    endsequence

    sequence s_fatal_request;
        ##1 protocol_flags_0[FATAL_ERROR_BIT] ##1 protocol_irq;
    endsequence

    a_fatal_gate_on: assert property (@(posedge core_clk) disable iff (rst)
        s_fatal_enabled |-> s_fatal_request)
        else $error("Enabled fatal error did not raise request");

    a_gated_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (((protocol_flags_0 & protocol_irq_enable_0_r) == 16'h0000)
         && ((protocol_flags_1 & protocol_irq_enable_1_r) == 16'h0000))
        |=> !protocol_irq)
        else $error("Request raised with no enabled flag");

    a_timer_two_gate: assert property (@(posedge core_clk) disable iff (rst)
        (protocol_flags_0[TIMER_TWO_BIT] && protocol_irq_enable_0_r[TIMER_TWO_BIT])
        |=> protocol_irq)
        else $error("Timer two flag enabled but no request");

    a_slot_gate: assert property (@(posedge core_clk) disable iff (rst)
        ((protocol_flags_1[SLOT_COUNTER_MSB:SLOT_COUNTER_LSB]
          & protocol_irq_enable_1_r[SLOT_COUNTER_MSB:SLOT_COUNTER_LSB]) != 4'h0)
        |=> protocol_irq)
        else $error("Slot counter flag enabled but no request");

    a_set_over_clear: assert property (@(posedge core_clk) disable iff (rst)
        (wr_fl_1 && wdata[STATE_CHANGE_BIT] && state_change_set)
        |=> protocol_flags_1[STATE_CHANGE_BIT])
        else $error("Clear beat a simultaneous set");

    a_zero_keeps: assert property (@(posedge core_clk) disable iff (rst)
        (wr_fl_0 && !wdata[CYCLE_START_BIT] && protocol_flags_0[CYCLE_START_BIT])
        |=> protocol_flags_0[CYCLE_START_BIT])
        else $error("Writing zero changed a flag");

    a_one_clears: assert property (@(posedge core_clk) disable iff (rst)
        (wr_fl_0 && wdata[CYCLE_START_BIT] && !cycle_start_set)
        |=> !protocol_flags_0[CYCLE_START_BIT])
        else $error("Writing one did not clear a flag");

    a_flag_sets_gated: assert property (@(posedge core_clk) disable iff (rst)
        (odd_table_set && !protocol_irq_enable_1_r[ODD_TABLE_BIT])
        |=> protocol_flags_1[ODD_TABLE_BIT])
        else $error("Disabled flag was not recorded");

    a_enable_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_en_1 |=> (protocol_irq_enable_1_r == ($past(wdata) & GROUP_1_MASK)))
        else $error("Second enable register did not take write");

    // Flag recorded one edge after its event, request one edge after that
    sequence s_flag_then_request(flag_seen);
        flag_seen ##1 protocol_irq;
    endsequence

    a_internal_gate: assert property (@(posedge core_clk) disable iff (rst)
        (internal_error_set && protocol_irq_enable_0_r[INTERNAL_ERROR_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[INTERNAL_ERROR_BIT]))
        else $error("Enabled internal error did not raise request");

    a_config_gate: assert property (@(posedge core_clk) disable iff (rst)
        (illegal_config_set && protocol_irq_enable_0_r[ILLEGAL_CONFIG_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[ILLEGAL_CONFIG_BIT]))
        else $error("Enabled configuration flag did not raise request");

    a_coldstart_gate: assert property (@(posedge core_clk) disable iff (rst)
        (coldstart_abort_set && protocol_irq_enable_0_r[COLDSTART_ABORT_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[COLDSTART_ABORT_BIT]))
        else $error("Enabled cold start abort did not raise request");

    a_correction_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!wr_en_0 && |({missing_rate_corr_set, missing_offset_corr_set}
                       & protocol_irq_enable_0_r[MISSING_RATE_BIT:MISSING_OFFSET_BIT]))
        |=> s_flag_then_request(|protocol_flags_0[MISSING_RATE_BIT:MISSING_OFFSET_BIT]))
        else $error("Enabled missing correction did not raise request");

    a_limit_gate: assert property (@(posedge core_clk) disable iff (rst)
        (corr_limit_set && protocol_irq_enable_0_r[CORR_LIMIT_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[CORR_LIMIT_BIT]))
        else $error("Enabled correction limit did not raise request");

    a_max_sync_gate: assert property (@(posedge core_clk) disable iff (rst)
        (max_sync_set && protocol_irq_enable_0_r[MAX_SYNC_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[MAX_SYNC_BIT]))
        else $error("Enabled max sync flag did not raise request");

    a_symbol_gate: assert property (@(posedge core_clk) disable iff (rst)
        (test_symbol_set && protocol_irq_enable_0_r[TEST_SYMBOL_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[TEST_SYMBOL_BIT]))
        else $error("Enabled test symbol flag did not raise request");

    a_latest_tx_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!wr_en_0 && |({latest_tx_b_set, latest_tx_a_set}
                       & protocol_irq_enable_0_r[LATEST_TX_B_BIT:LATEST_TX_A_BIT]))
        |=> s_flag_then_request(|protocol_flags_0[LATEST_TX_B_BIT:LATEST_TX_A_BIT]))
        else $error("Enabled latest transmit flag did not raise request");

    a_boundary_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!wr_en_0 && |({boundary_viol_b_set, boundary_viol_a_set}
                       & protocol_irq_enable_0_r[BOUNDARY_B_BIT:BOUNDARY_A_BIT]))
        |=> s_flag_then_request(|protocol_flags_0[BOUNDARY_B_BIT:BOUNDARY_A_BIT]))
        else $error("Enabled boundary flag did not raise request");

    a_timer_one_gate: assert property (@(posedge core_clk) disable iff (rst)
        (timer_one_set && protocol_irq_enable_0_r[TIMER_ONE_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[TIMER_ONE_BIT]))
        else $error("Enabled timer one flag did not raise request");

    a_cycle_gate: assert property (@(posedge core_clk) disable iff (rst)
        (cycle_start_set && protocol_irq_enable_0_r[CYCLE_START_BIT] && !wr_en_0)
        |=> s_flag_then_request(protocol_flags_0[CYCLE_START_BIT]))
        else $error("Enabled cycle start flag did not raise request");

    a_error_mode_gate: assert property (@(posedge core_clk) disable iff (rst)
        (error_mode_change_set && protocol_irq_enable_1_r[ERROR_MODE_BIT] && !wr_en_1)
        |=> s_flag_then_request(protocol_flags_1[ERROR_MODE_BIT]))
        else $error("Enabled error mode flag did not raise request");

    a_command_gate: assert property (@(posedge core_clk) disable iff (rst)
        (illegal_command_set && protocol_irq_enable_1_r[ILLEGAL_CMD_BIT] && !wr_en_1)
        |=> s_flag_then_request(protocol_flags_1[ILLEGAL_CMD_BIT]))
        else $error("Enabled command flag did not raise request");

    a_engine_fail_gate: assert property (@(posedge core_clk) disable iff (rst)
        (engine_comm_fail_set && protocol_irq_enable_1_r[ENGINE_FAIL_BIT] && !wr_en_1)
        |=> s_flag_then_request(protocol_flags_1[ENGINE_FAIL_BIT]))
        else $error("Enabled engine failure flag did not raise request");

    a_state_gate: assert property (@(posedge core_clk) disable iff (rst)
        (state_change_set && protocol_irq_enable_1_r[STATE_CHANGE_BIT] && !wr_en_1)
        |=> s_flag_then_request(protocol_flags_1[STATE_CHANGE_BIT]))
        else $error("Enabled state change flag did not raise request");

    a_table_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!wr_en_1 && |({even_table_set, odd_table_set}
                       & protocol_irq_enable_1_r[EVEN_TABLE_BIT:ODD_TABLE_BIT]))
        |=> s_flag_then_request(|protocol_flags_1[EVEN_TABLE_BIT:ODD_TABLE_BIT]))
        else $error("Enabled table written flag did not raise request");

endmodule

//--- dv/tb_protocol_irq_gate.sv
// Self-checking bench for protocol interrupt enable gating, with a cycle model
`timescale 1ns/10ps
module tb_protocol_irq_gate
    import prot_irq_pkg::*;
;
    logic              core_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_stb;
    logic              rd_stb;
    logic [DATA_W-1:0] rdata;
    logic              protocol_irq;
    logic [15:0]       s0;
    logic [15:0]       s1;
    logic [15:0]       en0_m, en1_m, fl0_m, fl1_m, rd_m, got;
    logic              irq_m;
    int                fail_count;
    int                check_count;
    int                cyc;
    logic [7:0]        ofs [6];

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    protocol_irq_gate uut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata),
        .fatal_error_set(s0[15]), .internal_error_set(s0[14]), .illegal_config_set(s0[13]),
        .coldstart_abort_set(s0[12]), .missing_rate_corr_set(s0[11]),
        .missing_offset_corr_set(s0[10]), .corr_limit_set(s0[9]), .max_sync_set(s0[8]),
        .test_symbol_set(s0[7]), .latest_tx_b_set(s0[6]), .latest_tx_a_set(s0[5]),
        .boundary_viol_b_set(s0[4]), .boundary_viol_a_set(s0[3]), .timer_two_set(s0[2]),
        .timer_one_set(s0[1]), .cycle_start_set(s0[0]),
        .error_mode_change_set(s1[15]), .illegal_command_set(s1[14]),
        .engine_comm_fail_set(s1[13]), .state_change_set(s1[12]),
        .slot_counter_set(s1[11:8]), .even_table_set(s1[5]), .odd_table_set(s1[4]),
        .protocol_irq(protocol_irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model; all terms use values from before the edge, like the registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {en0_m, en1_m, fl0_m, fl1_m, rd_m} <= '0;
            irq_m <= 1'b0;
        end else begin
            irq_m <= |(fl0_m & en0_m) | |(fl1_m & en1_m);
            rd_m  <= '0;
            if (rd_stb) begin
                case (addr)
                    FLAGS_0_OFS:  rd_m <= fl0_m;
                    FLAGS_1_OFS:  rd_m <= fl1_m;
                    ENABLE_0_OFS: rd_m <= en0_m;
                    ENABLE_1_OFS: rd_m <= en1_m;
                    PENDING_OFS:  rd_m <= {14'h0000, |(fl1_m & en1_m), |(fl0_m & en0_m)};
                    default:      rd_m <= '0;
                endcase
            end
            // Set wins over a clear landing in the same cycle
            fl0_m <= (fl0_m & ~((wr_stb && addr == FLAGS_0_OFS) ? wdata : 16'h0000)) | s0;
            fl1_m <= (fl1_m & ~((wr_stb && addr == FLAGS_1_OFS) ? wdata : 16'h0000))
                     | (s1 & GROUP_1_MASK);
            if (wr_stb && addr == ENABLE_0_OFS) en0_m <= wdata;
            if (wr_stb && addr == ENABLE_1_OFS) en1_m <= wdata & GROUP_1_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, reporting and the single end of the run
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Every cycle out of reset the outputs must match the model
    always @(negedge core_clk) begin
        if (!rst) begin
            chk(rdata, rd_m);
            chk({15'h0000, protocol_irq}, {15'h0000, irq_m});
        end
    end

    // Hang guard; the planned sequence needs well under 3000 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port tasks: one-cycle strobes changed right after an edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse(input int g, input logic [15:0] m);
        @(posedge core_clk);
        if (g == 0) s0 <= m;
        else s1 <= m;
        @(posedge core_clk);
        s0 <= '0;
        s1 <= '0;
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] m;
        int          op;
        {rst, addr, wdata, wr_stb, rd_stb, s0, s1} = '0;
        rst = 1'b1;
        {fail_count, check_count} = '0;
        ofs = '{FLAGS_0_OFS, FLAGS_1_OFS, ENABLE_0_OFS, ENABLE_1_OFS, PENDING_OFS, 8'h20};
        void'($urandom(2040));
        do_reset();
        // Reset values, read-only and unmapped places, reserved bits
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], got);
            chk(got, 16'h0000);
        end
        wr(ENABLE_1_OFS, 16'hffff);
        wr(PENDING_OFS, 16'hffff);
        rd(ENABLE_1_OFS, got);
        chk(got, 16'hff30);
        wr(ENABLE_1_OFS, 16'h0000);
        // Each flag blocked by a cleared enable, then released by setting it
        for (int g = 0; g < 2; g++) begin
            for (int b = 0; b < 16; b++) begin
                m = 16'h0001 << b;
                if (g == 1 && (m & GROUP_1_MASK) == 16'h0000) continue;
                wr(g ? ENABLE_1_OFS : ENABLE_0_OFS, ~m);
                pulse(g, m);
                settle();
                chk({15'h0000, protocol_irq}, 16'h0000);
                wr(g ? ENABLE_1_OFS : ENABLE_0_OFS, m);
                settle();
                chk({15'h0000, protocol_irq}, 16'h0001);
                rd(PENDING_OFS, got);
                chk(got, g ? 16'h0002 : 16'h0001);
                wr(g ? FLAGS_1_OFS : FLAGS_0_OFS, ~m);
                rd(g ? FLAGS_1_OFS : FLAGS_0_OFS, got);
                chk(got, m);
                wr(g ? FLAGS_1_OFS : FLAGS_0_OFS, m);
                settle();
                chk({15'h0000, protocol_irq}, 16'h0000);
            end
        end
        // Clear and set of the same flag in one cycle keeps it
        @(posedge core_clk);
        s0     <= 16'h8000;
        addr   <= FLAGS_0_OFS;
        wdata  <= 16'h8000;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        s0     <= '0;
        wr_stb <= 1'b0;
        rd(FLAGS_0_OFS, got);
        chk(got, 16'h8000);
        // Random traffic: events, writes and reads in any mix, back to back
        for (int i = 0; i < 1500; i++) begin
            @(posedge core_clk);
            op     = $urandom_range(2);
            s0     <= (($urandom_range(3) == 0) ? 16'($urandom) : 16'h0000);
            s1     <= (($urandom_range(3) == 0) ? 16'($urandom) : 16'h0000);
            addr   <= ofs[$urandom_range(5)];
            wdata  <= 16'($urandom);
            wr_stb <= (op == 1);
            rd_stb <= (op == 2);
            if (i == 900) rst <= 1'b1;
            if (i == 903) rst <= 1'b0;
        end
        @(posedge core_clk);
        {s0, s1, wr_stb, rd_stb} <= '0;
        for (int i = 0; i < 5; i++) rd(ofs[i], got);
        settle();
        print_verdict();
    end
endmodule
